/* File: rtl/ccc_top.sv */
// Configuration and control logic of a light-harvesting battery charger.
// Assumes pins arrive asynchronously, temperature code comes from logic
// on clk, and one AHB-Lite master owns the register bus.
//
// Notes on behaviour
// RL1 - The serial address is 0x41 with the select pin high, 0x40 low.
// RL2 - An unconnected address select pin reads as high.
// RL3 - Small package: one ratio pin picks one of two ratios, open is high.
// RL4 - Charge inhibit stops charging; an open inhibit pin reads as low.
// RL5 - Ratio has 9 bus values, 8 from large-package pins, 2 from small.
// RL6 - Tracking interval and sensing time are set as one of eight pairs.
// RL7 - Battery limits reset to defaults and step in 60 mV by bus or pins.
// RL8 - With thermal protection on, charging stops outside the window.
// RL9 - On battery supply the block stays up while above overdischarge.
// RL10 - On harvester supply, energy loss forces a full cold start.
// RL11 - Without bus writes the block runs on defaults plus pin settings.
// RL12 - Supply select high powers from battery, low from harvester.
// RL13 - Pins are sampled after reset; later bus writes override them.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps

module ccc_top
    import ccc_pkg::*;
(
    input  wire logic        clk,               // 100 MHz clock
    input  wire logic        rst_n,             // async reset
    input  wire ccc_pins_t   pin_level,         // raw pin levels
    input  wire ccc_pins_t   pin_open,          // pin left unconnected
    input  wire logic [7:0]  temp_code,         // measured temperature
    input  wire logic        hsel,              // AHB select
    input  wire logic [31:0] haddr,             // AHB address
    input  wire logic [1:0]  htrans,            // AHB transfer type
    input  wire logic        hwrite,            // AHB write
    input  wire logic [2:0]  hsize,             // AHB size
    input  wire logic [31:0] hwdata,            // AHB write data
    input  wire logic        hready,            // AHB bus ready
    output logic [31:0]      hrdata,            // AHB read data
    output logic             hreadyout,         // AHB slave ready
    output logic             hresp,             // AHB response
    output logic [6:0]       bus_addr,          // serial bus address
    output ccc_cfg_t         cfg,               // active configuration
    output logic             charge_enable,     // boost may charge
    output logic             supply_from_batt,  // rail source select
    output logic             cold_start_req     // cold start running
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    ccc_pins_t lvl_s1_reg, lvl_s2_reg, opn_s1_reg, opn_s2_reg;
    ccc_pins_t pins;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lvl_s1_reg <= '0;
            lvl_s2_reg <= '0;
            opn_s1_reg <= '0;
            opn_s2_reg <= '0;
        end
        else
        begin
            lvl_s1_reg <= pin_level;
            lvl_s2_reg <= lvl_s1_reg;
            opn_s1_reg <= pin_open;
            opn_s2_reg <= opn_s1_reg;
        end
    end

    // Open pins take their pull level after synchronising.
    assign pins = (lvl_s2_reg & ~opn_s2_reg)
                | (PIN_PULL & opn_s2_reg); // RL2 RL3 RL4

    open_inhibit_a: assert property (@(posedge clk) disable iff (!rst_n) // RL4
        opn_s2_reg.inhibit |-> !pins.inhibit)
        else $error("open inhibit pin not read as low");
    open_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // RL2
        opn_s2_reg.addr_sel |-> pins.addr_sel)
        else $error("open address pin not read as high");

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] ratio_from_pins(logic [2:0] p,
                                                   logic is_small);
        logic [3:0] r;
        r = is_small ? (p[0] ? RATIO_SMALL_HI : RATIO_SMALL_LO) // RL3
                  : {1'b0, p} + 4'h1;                        // RL5
        return r;
    endfunction : ratio_from_pins

    // All-high pins keep the default; each step below moves 60 mV.
    function automatic logic [4:0] limit_from_pins(logic [4:0] def,
                                                   logic [2:0] p,
                                                   logic is_small);
        logic [4:0] v;
        v = is_small ? def : def - {2'b00, ~p};
        return v;
    endfunction : limit_from_pins

    function automatic ccc_cfg_t cfg_from_pins(ccc_pins_t p);
        ccc_cfg_t c;
        c.ratio  = ratio_from_pins(p.ratio, p.pkg_small);
        c.timing = p.pkg_small ? TIMING_DEF : p.timing; // RL6
        c.ovch   = limit_from_pins(OVCH_DEF, p.limit, p.pkg_small); // RL7
        c.ovdis  = limit_from_pins(OVDIS_DEF, p.limit, p.pkg_small);
        return c;
    endfunction : cfg_from_pins

    // ------------------------------------------------------------
    // Power state and configuration
    // ------------------------------------------------------------
    localparam ccc_cfg_t CFG_DEF = '{ratio: RATIO_MAX, timing: TIMING_DEF,
                                    ovch: OVCH_DEF, ovdis: OVDIS_DEF};

    ccc_pstate_t ps_reg, ps_next;
    logic [15:0] cnt_reg, cnt_next;
    ccc_cfg_t    cfg_reg, cfg_next;
    logic [6:0]  addr_reg, addr_next;
    logic        th_en_reg, th_en_next;
    logic [7:0]  th_low_reg, th_low_next, th_high_reg, th_high_next;
    logic        pkg_small_reg, pkg_small_next;
    logic        charge_reg, charge_next, cold_reg, cold_next;
    logic        batt_reg, batt_next;
    logic        rail_lost, th_block, wr_hit;
    logic [7:0]  wr_ofs_reg, wr_ofs_next;
    logic        wr_pend_reg, wr_pend_next;

    // Battery supply keeps the rail while above overdischarge; harvester
    // supply keeps it only while energy is present.
    assign rail_lost = pins.supply_sel ? !pins.batt_ok // RL9 RL12
                                       : !pins.harv_ok; // RL10
    assign th_block  = th_en_reg && (temp_code < th_low_reg
                                  || temp_code > th_high_reg); // RL8
    assign wr_hit    = wr_pend_reg;

    always_comb
    begin
        ps_next        = ps_reg;
        cnt_next       = cnt_reg;
        cfg_next       = cfg_reg;
        addr_next      = addr_reg;
        th_en_next     = th_en_reg;
        th_low_next    = th_low_reg;
        th_high_next   = th_high_reg;
        pkg_small_next = pkg_small_reg;
        case (ps_reg)
            PS_SAMPLE:
            begin
                // Wait until the synchronisers carry real pin levels.
                if (cnt_reg == 16'(SAMPLE_WAIT))
                begin
                    cfg_next       = cfg_from_pins(pins); // RL11 RL13
                    addr_next      = pins.addr_sel ? ADDR_SEL_HI
                                                   : ADDR_SEL_LO; // RL1
                    pkg_small_next = pins.pkg_small;
                    cnt_next       = '0;
                    ps_next        = PS_RUN;
                end
                else
                begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end
            PS_RUN:
            begin
                if (rail_lost)
                begin
                    // The rail collapses: all bus settings are lost.
                    ps_next      = PS_COLD; // RL10
                    cnt_next     = '0;
                    cfg_next     = CFG_DEF;
                    th_en_next   = 1'b0;
                    th_low_next  = TH_LOW_DEF;
                    th_high_next = TH_HIGH_DEF;
                end
                else if (wr_hit)
                begin
                    case (wr_ofs_reg) // RL13
                        OFS_RATIO:
                            if (hwdata[3:0] <= RATIO_MAX)
                            begin
                                cfg_next.ratio = hwdata[3:0]; // RL5
                            end
                        OFS_TIMING:
                            cfg_next.timing = hwdata[2:0]; // RL6
                        OFS_LIMITS:
                        begin
                            cfg_next.ovch  = hwdata[LIM_OVCH_LSB +: 5];
                            cfg_next.ovdis = hwdata[LIM_OVDIS_LSB +: 5];
                        end
                        OFS_THERMAL:
                        begin
                            th_en_next   = hwdata[TH_EN_BIT];
                            th_low_next  = hwdata[TH_LOW_LSB +: 8];
                            th_high_next = hwdata[TH_HIGH_LSB +: 8];
                        end
                        default:
                            cfg_next = cfg_reg;
                    endcase
                end
            end
            PS_COLD:
            begin
                // Cold start needs harvester energy held without a break.
                if (!pins.harv_ok)
                begin
                    cnt_next = '0;
                end
                else if (cnt_reg == 16'(COLD_CYCLES - 1))
                begin
                    cnt_next = '0;
                    ps_next  = PS_SAMPLE; // RL10
                end
                else
                begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end
            default:
                ps_next = PS_SAMPLE;
        endcase
        charge_next = ps_reg == PS_RUN && !rail_lost
                   && !pins.inhibit && !th_block; // RL4 RL8
        cold_next   = ps_next == PS_COLD;
        batt_next   = pins.supply_sel; // RL12
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ps_reg        <= PS_SAMPLE;
            cnt_reg       <= '0;
            cfg_reg       <= CFG_DEF;
            addr_reg      <= ADDR_SEL_HI;
            th_en_reg     <= 1'b0;
            th_low_reg    <= TH_LOW_DEF;
            th_high_reg   <= TH_HIGH_DEF;
            pkg_small_reg <= 1'b0;
            charge_reg    <= 1'b0;
            cold_reg      <= 1'b0;
            batt_reg      <= 1'b0;
        end
        else
        begin
            ps_reg        <= ps_next;
            cnt_reg       <= cnt_next;
            cfg_reg       <= cfg_next;
            addr_reg      <= addr_next;
            th_en_reg     <= th_en_next;
            th_low_reg    <= th_low_next;
            th_high_reg   <= th_high_next;
            pkg_small_reg <= pkg_small_next;
            charge_reg    <= charge_next;
            cold_reg      <= cold_next;
            batt_reg      <= batt_next;
        end
    end

    addr_pick_a: assert property (@(posedge clk) disable iff (!rst_n) // RL1
        ps_reg == PS_SAMPLE && ps_next == PS_RUN
        |=> bus_addr == ($past(pins.addr_sel) ? 7'h41 : 7'h40))
        else $error("bus address does not follow select pin");
    inhibit_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // RL4
        pins.inhibit |=> !charge_enable)
        else $error("charging while inhibit is asserted");
    thermal_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // RL8
        th_block |=> !charge_enable)
        else $error("charging outside thermal window");
    ratio_range_a: assert property (@(posedge clk) disable iff (!rst_n) // RL5
        cfg.ratio <= 4'h8)
        else $error("tracking ratio outside nine values");
    batt_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RL9
        ps_reg == PS_RUN && pins.supply_sel && pins.batt_ok
        |=> ps_reg == PS_RUN)
        else $error("battery supplied block left run state");
    rail_loss_a: assert property (@(posedge clk) disable iff (!rst_n) // RL10
        ps_reg == PS_RUN && rail_lost
        |=> ps_reg == PS_COLD && cfg == CFG_DEF ##1 !charge_enable)
        else $error("rail loss did not force a cold start");
    cold_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RL10
        ps_reg == PS_COLD && !pins.harv_ok |=> ps_reg == PS_COLD)
        else $error("cold start ended without harvester energy");
    bus_override_a: assert property (@(posedge clk) disable iff (!rst_n) // RL13
        ps_reg == PS_RUN && !rail_lost && wr_hit
        && wr_ofs_reg == OFS_TIMING
        |=> cfg.timing == $past(hwdata[2:0]))
        else $error("bus write did not override timing pair");

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    logic [31:0] rdata_reg, rdata_next;
    logic        addr_ok;

    assign addr_ok = hsel && hready && htrans[1];

    function automatic logic [31:0] read_mux(logic [7:0] ofs,
                                             ccc_cfg_t c,
                                             logic en,
                                             logic [7:0] lo,
                                             logic [7:0] hi);
        logic [31:0] d;
        d = '0;
        case (ofs)
            OFS_RATIO:   d[3:0] = c.ratio;
            OFS_TIMING:  d[2:0] = c.timing;
            OFS_LIMITS:
            begin
                d[LIM_OVCH_LSB +: 5]  = c.ovch;
                d[LIM_OVDIS_LSB +: 5] = c.ovdis;
            end
            OFS_THERMAL:
            begin
                d[TH_EN_BIT]        = en;
                d[TH_LOW_LSB +: 8]  = lo;
                d[TH_HIGH_LSB +: 8] = hi;
            end
            default:     d = '0;
        endcase
        return d;
    endfunction : read_mux

    always_comb
    begin
        wr_pend_next = addr_ok && hwrite;
        wr_ofs_next  = haddr[7:0];
        // Reads use next-state values, except the package and thermal status bits,
        // so a read right after a write already returns the written data.
        rdata_next   = rdata_reg;
        if (addr_ok && !hwrite)
        begin
            if (haddr[7:0] == OFS_STATUS && haddr[31:8] == '0)
            begin
                rdata_next = {26'h0, pkg_small_reg, th_block, cold_next,
                              batt_next, charge_next,
                              ps_next == PS_RUN};
            end
            else if (haddr[31:8] == '0)
            begin
                rdata_next = read_mux(haddr[7:0], cfg_next, th_en_next,
                                      th_low_next, th_high_next);
            end
            else
            begin
                rdata_next = '0;
            end
        end
        if (addr_ok && hwrite && haddr[31:8] != '0)
        begin
            wr_ofs_next = OFS_STATUS;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg   <= '0;
            wr_pend_reg <= 1'b0;
            wr_ofs_reg  <= '0;
        end
        else
        begin
            rdata_reg   <= rdata_next;
            wr_pend_reg <= wr_pend_next;
            wr_ofs_reg  <= wr_ofs_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic ready_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_reg <= 1'b0;
        end
        else
        begin
            ready_reg <= 1'b1;
        end
    end

    assign hrdata           = rdata_reg;
    assign hreadyout        = ready_reg;
    assign hresp            = 1'b0;
    assign bus_addr         = addr_reg;
    assign cfg              = cfg_reg;
    assign charge_enable    = charge_reg;
    assign supply_from_batt = batt_reg;
    assign cold_start_req   = cold_reg;

endmodule : ccc_top

/* File: inc/ccc_pkg.sv */
// Constants, field layouts and carrier types for the charger
// configuration and control block.
// Assumes one 100 MHz clock and an AHB-Lite register bus of 32 bits.
package ccc_pkg;

    // ------------------------------------------------------------
    // Bus addresses and timing
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_SEL_HI   = 7'h41;
    localparam logic [6:0] ADDR_SEL_LO   = 7'h40;
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         COLD_TIME_NS  = 10000;
    localparam int         COLD_CYCLES   =
        (COLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         SAMPLE_WAIT   = 3;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_RATIO   = 8'h00;
    localparam logic [7:0] OFS_TIMING  = 8'h04;
    localparam logic [7:0] OFS_LIMITS  = 8'h08;
    localparam logic [7:0] OFS_THERMAL = 8'h0c;
    localparam logic [7:0] OFS_STATUS  = 8'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         LIM_OVCH_LSB  = 0;
    localparam int         LIM_OVDIS_LSB = 8;
    localparam int         TH_EN_BIT     = 0;
    localparam int         TH_LOW_LSB    = 8;
    localparam int         TH_HIGH_LSB   = 16;
    localparam logic [3:0] RATIO_MAX     = 4'h8;
    localparam logic [3:0] RATIO_SMALL_HI = 4'h4;
    localparam logic [3:0] RATIO_SMALL_LO = 4'h2;
    localparam logic [2:0] TIMING_DEF    = 3'h0;
    localparam logic [4:0] OVCH_DEF      = 5'h1e;
    localparam logic [4:0] OVDIS_DEF     = 5'h05;
    localparam logic [7:0] TH_LOW_DEF    = 8'h00;
    localparam logic [7:0] TH_HIGH_DEF   = 8'hff;

    // Configuration that steers the analogue side.
    typedef struct packed {
        logic [3:0] ratio;
        logic [2:0] timing;
        logic [4:0] ovch;
        logic [4:0] ovdis;
    } ccc_cfg_t;

    // Pin group, used both for levels and for unconnected flags.
    typedef struct packed {
        logic       addr_sel;
        logic [2:0] ratio;
        logic [2:0] timing;
        logic [2:0] limit;
        logic       inhibit;
        logic       supply_sel;
        logic       pkg_small;
        logic       batt_ok;
        logic       harv_ok;
    } ccc_pins_t;

    // Level that an unconnected pin reads as.
    localparam ccc_pins_t PIN_PULL = '{
        addr_sel: 1'b1, ratio: 3'h7, timing: 3'h7, limit: 3'h7,
        inhibit: 1'b0, supply_sel: 1'b0, pkg_small: 1'b0,
        batt_ok: 1'b0, harv_ok: 1'b0};

    typedef enum logic [1:0] {PS_SAMPLE, PS_RUN, PS_COLD} ccc_pstate_t;

endpackage : ccc_pkg

/* File: bench/ccc_host_model.sv */
// Host model: an AHB-Lite master issuing single whole-word transfers.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ps

module ccc_host_model
(
    input  wire logic        clk,    // bus clock
    input  wire logic        hready, // slave ready
    input  wire logic [31:0] hrdata, // read data
    output logic             hsel,   // slave select
    output logic [31:0]      haddr,  // address
    output logic [1:0]       htrans, // transfer type
    output logic             hwrite, // write strobe
    output logic [2:0]       hsize,  // always one word
    output logic [31:0]      hwdata  // write data
);
    initial
    begin
        hsel   = 1'b1;
        haddr  = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // Called right after a rising edge; returns right after one.
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= w ? d : ~hwdata;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        // A released data bus must not keep showing the old word.
        hwdata <= ~d;
    endtask : xfer
endmodule : ccc_host_model

/* File: bench/tb_charger_config_control.sv */
// Self-checking bench for the charger configuration block.
// Assumes the host model drives the register bus.
`timescale 1ns/1ps

module tb_charger_config_control
    import ccc_pkg::*;
;
    typedef struct packed {
        ccc_pins_t  lv;
        ccc_pins_t  op;
        logic [6:0] a;
        ccc_cfg_t   c;
        logic       ce;
    } ccc_row_t;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    ccc_pins_t   pin_level = '0;
    ccc_pins_t   pin_open = '0;
    logic [7:0]  temp_code = 8'h30;
    logic        hsel, hwrite, hreadyout, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [6:0]  bus_addr;
    ccc_cfg_t    cfg;
    logic        charge_enable, supply_from_batt, cold_start_req;
    int          bad_count = 0;
    int          n_tests = 0;
    int          k;
    ccc_row_t    rows[5];
    logic [8:0]  temps[4] = '{9'h010, 9'h121, 9'h140, 9'h041};

    always #5 clk = ~clk;

    ccc_top dut (.clk(clk), .rst_n(rst_n), .pin_level(pin_level),
        .pin_open(pin_open), .temp_code(temp_code), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .bus_addr(bus_addr),
        .cfg(cfg), .charge_enable(charge_enable),
        .supply_from_batt(supply_from_batt),
        .cold_start_req(cold_start_req));

    ccc_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    // Large package unless sm; battery supply with both rails healthy.
    function automatic ccc_pins_t mk(logic ad, logic [2:0] r,
        logic [2:0] t, logic [2:0] l, logic inh, logic sm);
        return '{ad, r, t, l, inh, 1'b1, sm, 1'b1, 1'b1};
    endfunction : mk

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    initial
    begin
        #100us;
        bad_count++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Pin rows, then hand-written cases
    // ------------------------------------------------------------
    initial
    begin
        rows[0] = '{mk(0, 0, 0, 0, 1, 0), 15'h7ff0, 7'h41,
                    '{4'h8, 3'h7, 5'h1e, 5'h05}, 1'b1};
        rows[1] = '{mk(0, 0, 3, 5, 0, 0), 15'h0, 7'h40,
                    '{4'h1, 3'h3, 5'h1c, 5'h03}, 1'b1};
        rows[2] = '{mk(1, 1, 5, 2, 0, 1), 15'h0, 7'h41,
                    '{4'h4, 3'h0, 5'h1e, 5'h05}, 1'b1};
        rows[3] = '{mk(0, 6, 0, 0, 1, 1), 15'h0, 7'h40,
                    '{4'h2, 3'h0, 5'h1e, 5'h05}, 1'b0};
        rows[4] = '{mk(1, 0, 0, 0, 1, 1), 15'h3810, 7'h41,
                    '{4'h4, 3'h0, 5'h1e, 5'h05}, 1'b1};
        repeat (8) @(posedge clk);
        foreach (rows[i])
        begin
            rst_n <= 1'b0;
            pin_level <= rows[i].lv;
            pin_open <= rows[i].op;
            @(posedge clk);
            rst_n <= 1'b1;
            repeat (8) @(posedge clk);
            chk("bus_addr", 32'(rows[i].a), 32'(bus_addr));
            chk("cfg", 32'(rows[i].c), 32'(cfg));
            chk("charge_enable", 32'(rows[i].ce), 32'(charge_enable));
            $display("pin row %0d done", i);
        end
        host.xfer(1, 32'h0, 32'h0, q);
        host.xfer(1, 32'h0, 32'h9, q);
        host.xfer(1, 32'h4, 32'h5, q);
        host.xfer(1, 32'h8, 32'h0710, q);
        host.xfer(0, 32'h0, 32'h0, q);
        chk("ratio read", 32'h0, q);
        host.xfer(0, 32'h20, 32'h0, q);
        chk("unmapped read", 32'h0, q);
        @(posedge clk);
        chk("cfg", 32'(ccc_cfg_t'{4'h0, 3'h5, 5'h10, 5'h07}), 32'(cfg));
        $display("bus override done");
        host.xfer(1, 32'hc, 32'h0040_2001, q);
        foreach (temps[i])
        begin
            temp_code <= temps[i][7:0];
            repeat (4) @(posedge clk);
            chk("thermal charge", 32'(temps[i][8]), 32'(charge_enable));
        end
        host.xfer(1, 32'hc, 32'h0, q);
        repeat (4) @(posedge clk);
        chk("thermal off", 32'h1, 32'(charge_enable));
        $display("thermal done");
        pin_open <= 15'h3800;
        repeat (4) @(posedge clk);
        chk("inhibit", 32'h0, 32'(charge_enable));
        pin_open <= 15'h3810;
        pin_level.harv_ok <= 1'b0;
        repeat (8) @(posedge clk);
        chk("keep alive", 32'h0, 32'({cold_start_req, cfg.ratio}));
        chk("batt supply", 32'h1, 32'(supply_from_batt));
        pin_level.supply_sel <= 1'b0;
        repeat (4) @(posedge clk);
        chk("rail loss", 32'h18, 32'({cold_start_req, cfg.ratio}));
        chk("harv supply", 32'h0, 32'(supply_from_batt));
        pin_level.harv_ok <= 1'b1;
        repeat (900) @(posedge clk);
        chk("cold held", 32'h1, 32'(cold_start_req));
        k = 0;
        while (cold_start_req !== 1'b0 && k < 300)
        begin
            @(posedge clk);
            k++;
        end
        repeat (8) @(posedge clk);
        chk("recapture", 32'(rows[4].c), 32'(cfg));
        host.xfer(0, 32'h10, 32'h0, q);
        chk("status", 32'h23, q);
        chk("hresp", 32'h0, 32'(hresp));
        $display("power cases done");
        finish_test();
    end
endmodule : tb_charger_config_control
